//--- core/frac_fault_ctrl.sv
`default_nettype none
module frac_fault_ctrl #(
	parameter int unsigned MS_CYCLES = frac_pkg::MS_CYCLES
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	// decoded command port
	input  wire logic        cmd_valid_i,
	input  wire logic [1:0]  cmd_kind_i,
	input  wire logic [7:0]  cmd_code_i,
	input  wire logic [15:0] cmd_wdata_i,
	output logic             rsp_valid_o,
	output logic [15:0]      rsp_rdata_o,
	// fault monitors, same clock
	input  wire logic [15:0] fault_cond_i,
	// pins
	input  wire logic        run_pin_i,
	input  wire logic        vout_decayed_i,
	input  wire logic        fault_pin_i,
	output logic             fault_pin_o,
	output logic             fault_pin_oe_o,
	output logic             alert_pin_o,
	output logic             alert_pin_oe_o,
	// power stage
	output logic             output_enable_o
);
	import frac_pkg::*;

	typedef enum logic [2:0] {
		ST_RUN   = 3'b001,
		ST_OFF   = 3'b010,
		ST_RETRY = 3'b100
	} frac_state_t;

	frac_state_t state_q;
	frac_state_t state_d;

	logic [7:0]  action_q [NUM_RSP];
	logic [7:0]  mask_q   [NUM_MASK];
	logic [15:0] restart_q;
	logic [15:0] prop_q;
	logic [7:0]  chan_cfg_q;
	logic [7:0]  oper_q;
	logic [7:0]  st_vout_q;
	logic [7:0]  st_iout_q;
	logic [7:0]  st_input_q;
	logic [7:0]  st_temp_q;
	logic [7:0]  st_cml_q;
	logic [7:0]  st_mfr_q;
	logic [NUM_RSP-1:0] cond_prev_q;
	logic [NUM_RSP-1:0] cause_q;
	logic        on_prev_q;
	logic        run_m_q, run_q;
	logic        dec_m_q, dec_q;
	logic        flt_m_q, flt_q;

	logic [NUM_RSP-1:0] rsp_cond;
	logic [NUM_RSP-1:0] rsp_rise;
	logic [NUM_RSP-1:0] shut_hit;
	logic [NUM_RSP-1:0] retry_hit;
	logic        wr, rd, pc;
	logic        on_cmd, on_rise, clr_all;
	logic        bad_action, bad_mask, bad_cmd;
	logic        count_en, restart, waiting_decay;
	logic [15:0] status_word;
	logic [15:0] rdata_d;
	logic [15:0] prop_active;
	logic [15:0] ignore_bits;
	logic [3:0]  msel;
	logic [3:0]  rsel;

	// mask slot for a status code; top bit flags an accepted code
	function automatic logic [3:0] mask_slot(input logic [7:0] code);
		case (code)
			CMD_STATUS_VOUT:  mask_slot = {1'b1, MSK_VOUT};
			CMD_STATUS_IOUT:  mask_slot = {1'b1, MSK_IOUT};
			CMD_STATUS_TEMP:  mask_slot = {1'b1, MSK_TEMP};
			CMD_STATUS_CML:   mask_slot = {1'b1, MSK_CML};
			CMD_STATUS_INPUT: mask_slot = {1'b1, MSK_INPUT};
			CMD_STATUS_MFR:   mask_slot = {1'b1, MSK_MFR};
			default:          mask_slot = 4'h0;
		endcase
	endfunction

	// response slot for an action command code
	function automatic logic [3:0] rsp_slot(input logic [7:0] code);
		case (code)
			CMD_VIN_OV_RESP:  rsp_slot = {2'b10, 2'(RSP_VIN_OV)};
			CMD_OT_RESP:      rsp_slot = {2'b10, 2'(RSP_OT)};
			CMD_UT_RESP:      rsp_slot = {2'b10, 2'(RSP_UT)};
			CMD_TON_MAX_RESP: rsp_slot = {2'b10, 2'(RSP_TON)};
			default:          rsp_slot = 4'h0;
		endcase
	endfunction

	// sticky status: set wins over any clear
	function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] set,
			input logic clr, input logic w1c, input logic [7:0] wd);
		logic [7:0] kept;
		kept = clr ? 8'h00 : (w1c ? (cur & ~wd) : cur);
		return kept | set;
	endfunction

	// pins from outside pass two flops
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			run_m_q <= 1'b0;
			run_q   <= 1'b0;
			dec_m_q <= 1'b0;
			dec_q   <= 1'b0;
			flt_m_q <= 1'b1;
			flt_q   <= 1'b1;
		end else begin
			run_m_q <= run_pin_i;
			run_q   <= run_m_q;
			dec_m_q <= vout_decayed_i;
			dec_q   <= dec_m_q;
			flt_m_q <= fault_pin_i;
			flt_q   <= flt_m_q;
		end
	end

	assign wr = cmd_valid_i && cmd_kind_i == KIND_WRITE;
	assign rd = cmd_valid_i && cmd_kind_i == KIND_READ;
	assign pc = cmd_valid_i && cmd_kind_i == KIND_PROC;
	assign msel = mask_slot(cmd_wdata_i[7:0]);
	assign rsel = rsp_slot(cmd_code_i);

	assign on_cmd  = run_q && oper_q[OPERATION_ON_BIT];
	assign on_rise = on_cmd && !on_prev_q;
	assign clr_all = on_rise || (wr && (cmd_code_i == CMD_CLEAR_FAULTS ||
		cmd_code_i == CMD_RESTORE_ALL || cmd_code_i == CMD_SOFT_RESET));

	assign bad_action = wr && rsel[3] && cmd_wdata_i[6];
	assign bad_mask   = (wr || pc) && cmd_code_i == CMD_ALERT_MASK && !msel[3];

	always_comb begin
		bad_cmd = 1'b0;
		if (cmd_valid_i) begin
			case (cmd_code_i)
				CMD_OPERATION, CMD_CLEAR_FAULTS, CMD_RESTORE_ALL, CMD_ALERT_MASK,
				CMD_OT_RESP, CMD_UT_RESP, CMD_VIN_OV_RESP, CMD_TON_MAX_RESP,
				CMD_STATUS_BYTE, CMD_STATUS_WORD, CMD_STATUS_VOUT, CMD_STATUS_IOUT,
				CMD_STATUS_INPUT, CMD_STATUS_TEMP, CMD_STATUS_CML, CMD_STATUS_MFR,
				CMD_CHAN_CONFIG, CMD_FAULT_PIN_EN, CMD_PAD_STATE, CMD_COMMON_STATUS,
				CMD_RESTART_INT, CMD_SOFT_RESET: bad_cmd = 1'b0;
				default: bad_cmd = 1'b1;
			endcase
		end
	end

	// configuration writes
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			for (int i = 0; i < NUM_RSP; i++) action_q[i] <= ACTION_RST;
		end else if (wr && rsel[3] && !cmd_wdata_i[6]) begin
			action_q[rsel[1:0]] <= {cmd_wdata_i[7:3], 3'h0};
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			for (int i = 0; i < NUM_MASK; i++) mask_q[i] <= MASK_RST;
			mask_q[MSK_MFR] <= MASK_MFR_RST;
		end else if (wr && cmd_code_i == CMD_ALERT_MASK && msel[3]) begin
			mask_q[msel[2:0]] <= cmd_wdata_i[15:8];
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			restart_q  <= RESTART_RST;
			prop_q     <= PROP_RST;
			chan_cfg_q <= CHAN_CFG_RST;
			oper_q     <= OPER_RST;
		end else if (wr) begin
			if (cmd_code_i == CMD_RESTART_INT) restart_q <= cmd_wdata_i;
			if (cmd_code_i == CMD_FAULT_PIN_EN) prop_q <= cmd_wdata_i & PROP_WRITABLE;
			if (cmd_code_i == CMD_CHAN_CONFIG) chan_cfg_q <= cmd_wdata_i[7:0];
			if (cmd_code_i == CMD_OPERATION) oper_q <= cmd_wdata_i[7:0];
		end
	end

	// fault detection, one slot per response
	assign rsp_cond[RSP_VIN_OV] = fault_cond_i[PROP_VIN_OV];
	assign rsp_cond[RSP_OT]     = fault_cond_i[PROP_OT];
	assign rsp_cond[RSP_UT]     = fault_cond_i[PROP_UT];
	assign rsp_cond[RSP_TON]    = fault_cond_i[PROP_TON_MAX];
	assign rsp_rise = rsp_cond & ~cond_prev_q;

	always_comb begin
		for (int i = 0; i < NUM_RSP; i++) begin
			shut_hit[i]  = rsp_rise[i] && action_q[i][7:6] == ACT_SHUTDOWN;
			retry_hit[i] = shut_hit[i] && action_q[i][5:3] == RETRY_FOREVER;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cond_prev_q <= '0;
			on_prev_q   <= 1'b0;
		end else begin
			cond_prev_q <= rsp_cond;
			on_prev_q   <= on_cmd;
		end
	end

	// status registers; every action code still records the fault
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_vout_q  <= 8'h00;
			st_iout_q  <= 8'h00;
			st_input_q <= 8'h00;
			st_temp_q  <= 8'h00;
			st_cml_q   <= 8'h00;
			st_mfr_q   <= 8'h00;
		end else begin
			st_vout_q <= sticky(st_vout_q, 8'(rsp_rise[RSP_TON]) << VOUT_TON_MAX_BIT,
				clr_all, wr && cmd_code_i == CMD_STATUS_VOUT, cmd_wdata_i[7:0]);
			st_iout_q <= sticky(st_iout_q, 8'h00,
				clr_all, wr && cmd_code_i == CMD_STATUS_IOUT, cmd_wdata_i[7:0]);
			st_input_q <= sticky(st_input_q, 8'(rsp_rise[RSP_VIN_OV]) << INPUT_VIN_OV_BIT,
				clr_all, wr && cmd_code_i == CMD_STATUS_INPUT, cmd_wdata_i[7:0]);
			st_temp_q <= sticky(st_temp_q, (8'(rsp_rise[RSP_OT]) << TEMP_OT_BIT) |
				(8'(rsp_rise[RSP_UT]) << TEMP_UT_BIT),
				clr_all, wr && cmd_code_i == CMD_STATUS_TEMP, cmd_wdata_i[7:0]);
			st_cml_q <= sticky(st_cml_q, (8'(bad_action || bad_mask) << CML_BAD_DATA_BIT) |
				(8'(bad_cmd) << CML_BAD_CMD_BIT),
				clr_all, wr && cmd_code_i == CMD_STATUS_CML, cmd_wdata_i[7:0]);
			st_mfr_q <= sticky(st_mfr_q, 8'(!flt_q) << MFR_FAULT_LOW_BIT,
				clr_all, wr && cmd_code_i == CMD_STATUS_MFR, cmd_wdata_i[7:0]);
		end
	end

	// output control
	assign count_en = state_q == ST_RETRY && !(|(rsp_cond & cause_q)) && flt_q;

	frac_restart_timer #(
		.MS_CYCLES (MS_CYCLES)
	) u_timer (
		.clk_i           (clk_i),
		.srst_i          (srst_i),
		.count_en_i      (count_en),
		.interval_i      (restart_q),
		.decay_ok_i      (dec_q || !chan_cfg_q[CFG_DECAY_BIT]),
		.restart_o       (restart),
		.waiting_decay_o (waiting_decay)
	);

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_RUN: begin
				// action 00 never leaves this state
				if (|shut_hit) state_d = (shut_hit == retry_hit) ? ST_RETRY : ST_OFF;
			end
			ST_OFF: begin
				if (clr_all) state_d = ST_RUN;
			end
			ST_RETRY: begin
				if (|shut_hit && shut_hit != retry_hit) state_d = ST_OFF;
				else if (!on_cmd) state_d = ST_OFF;
				else if (restart) state_d = ST_RUN;
			end
			default: state_d = ST_OFF;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) state_q <= ST_RUN;
		else        state_q <= state_d;
	end

	// remember which responses hold the output off
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cause_q <= '0;
		end else if (state_d == ST_RUN) begin
			cause_q <= '0;
		end else if (|shut_hit) begin
			cause_q <= cause_q | shut_hit;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) output_enable_o <= 1'b0;
		else        output_enable_o <= state_d == ST_RUN && on_cmd;
	end

	// fault pin: propagate enables and ignore responses, alert masks play no part
	always_comb begin
		ignore_bits = 16'h0000;
		ignore_bits[PROP_VIN_OV]  = action_q[RSP_VIN_OV][7:6] == ACT_CONTINUE;
		ignore_bits[PROP_OT]      = action_q[RSP_OT][7:6] == ACT_CONTINUE;
		ignore_bits[PROP_UT]      = action_q[RSP_UT][7:6] == ACT_CONTINUE;
		ignore_bits[PROP_TON_MAX] = action_q[RSP_TON][7:6] == ACT_CONTINUE;
		prop_active = {waiting_decay, fault_cond_i[14:0]} & prop_q & ~ignore_bits;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			fault_pin_oe_o <= 1'b0;
			alert_pin_oe_o <= 1'b0;
		end else begin
			fault_pin_oe_o <= |prop_active;
			alert_pin_oe_o <= |(st_vout_q & ~mask_q[MSK_VOUT]) |
				|(st_iout_q & ~mask_q[MSK_IOUT]) | |(st_temp_q & ~mask_q[MSK_TEMP]) |
				|(st_cml_q & ~mask_q[MSK_CML]) | |(st_input_q & ~mask_q[MSK_INPUT]) |
				|(st_mfr_q & ~mask_q[MSK_MFR]);
		end
	end

	assign fault_pin_o = 1'b0;
	assign alert_pin_o = 1'b0;

	// readback
	always_comb begin
		status_word = 16'h0000;
		status_word[WORD_VOUT_BIT]  = |st_vout_q;
		status_word[WORD_INPUT_BIT] = |st_input_q;
		status_word[WORD_MFR_BIT]   = |st_mfr_q;
		status_word[BYTE_OFF_BIT]   = !output_enable_o;
		status_word[BYTE_TEMP_BIT]  = |st_temp_q;
		status_word[BYTE_CML_BIT]   = |st_cml_q;
	end

	always_comb begin
		rdata_d = 16'h0000;
		if (pc && cmd_code_i == CMD_ALERT_MASK && msel[3]) begin
			rdata_d = {8'h00, mask_q[msel[2:0]]};
		end else if (rd && rsel[3]) begin
			rdata_d = {8'h00, action_q[rsel[1:0]]};
		end else if (rd) begin
			case (cmd_code_i)
				CMD_OPERATION:    rdata_d = {8'h00, oper_q};
				CMD_STATUS_BYTE:  rdata_d = {8'h00, status_word[7:0]};
				CMD_STATUS_WORD:  rdata_d = status_word;
				CMD_STATUS_VOUT:  rdata_d = {8'h00, st_vout_q};
				CMD_STATUS_IOUT:  rdata_d = {8'h00, st_iout_q};
				CMD_STATUS_INPUT: rdata_d = {8'h00, st_input_q};
				CMD_STATUS_TEMP:  rdata_d = {8'h00, st_temp_q};
				CMD_STATUS_CML:   rdata_d = {8'h00, st_cml_q};
				CMD_STATUS_MFR:   rdata_d = {8'h00, st_mfr_q};
				CMD_CHAN_CONFIG:  rdata_d = {8'h00, chan_cfg_q};
				CMD_FAULT_PIN_EN: rdata_d = prop_q;
				CMD_RESTART_INT:  rdata_d = restart_q;
				default:          rdata_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rsp_valid_o <= 1'b0;
			rsp_rdata_o <= 16'h0000;
		end else begin
			rsp_valid_o <= cmd_valid_i;
			rsp_rdata_o <= rdata_d;
		end
	end
endmodule // frac_fault_ctrl
`default_nettype wire

//--- core/frac_pkg.sv
// How it works
// - start-up timeout sets its output-voltage status bits and raises alert unless masked.
// - every action code still sets the fault status bits and raises alert unless masked.
// - action 00 keeps the output regulating through the fault.
// - action 01 or 11 is refused and flags an invalid-data comm fault.
// - action 10 turns the output off at once, then follows the retry field.
// - retry codes 000-110 never restart; wait for clear, off-on cycle or power.
// - retry code 111 restarts forever, spaced by the restart interval.
// - the low three bits of an action byte are ignored and read back zero.
// - latched faults hold until clear, write-one, off-on, restore, soft reset or power.
// - the restart interval, in milliseconds, spaces every retrying response.
// - restart waits for the interval and for the output to decay below 12.5%.
// - a channel configuration bit turns off the decay qualification.
// - the interval counts only once the fault is gone and the fault pin released.
// - the interval is a linear word, 5-bit exponent and 11-bit mantissa.
// - mask bits line up with status bits; masked bits set status but not alert.
// - mask readback is a process call returning the mask of the given status code.
// - masks for status byte, word, common and pad registers are refused with comm fault.
// - masks reset to 0x00, except the vendor status mask which resets to 0x11.
// - each set propagate-enable bit lets its condition pull the fault pin low.
// - a condition whose response is set to ignore never pulls the fault pin.
// - the fault pin does not depend on any alert mask.
// - propagate-enable bits follow the fixed map; reserved bits stay zero.
`default_nettype none
package frac_pkg;
	// transaction kinds from the serial front end
	localparam logic [1:0] KIND_WRITE = 2'h0;
	localparam logic [1:0] KIND_READ  = 2'h1;
	localparam logic [1:0] KIND_PROC  = 2'h2;

	// command codes
	localparam logic [7:0] CMD_OPERATION     = 8'h01;
	localparam logic [7:0] CMD_CLEAR_FAULTS  = 8'h03;
	localparam logic [7:0] CMD_RESTORE_ALL   = 8'h16;
	localparam logic [7:0] CMD_ALERT_MASK    = 8'h1B;
	localparam logic [7:0] CMD_OT_RESP       = 8'h50;
	localparam logic [7:0] CMD_UT_RESP       = 8'h54;
	localparam logic [7:0] CMD_VIN_OV_RESP   = 8'h56;
	localparam logic [7:0] CMD_TON_MAX_RESP  = 8'h63;
	localparam logic [7:0] CMD_STATUS_BYTE   = 8'h78;
	localparam logic [7:0] CMD_STATUS_WORD   = 8'h79;
	localparam logic [7:0] CMD_STATUS_VOUT   = 8'h7A;
	localparam logic [7:0] CMD_STATUS_IOUT   = 8'h7B;
	localparam logic [7:0] CMD_STATUS_INPUT  = 8'h7C;
	localparam logic [7:0] CMD_STATUS_TEMP   = 8'h7D;
	localparam logic [7:0] CMD_STATUS_CML    = 8'h7E;
	localparam logic [7:0] CMD_STATUS_MFR    = 8'h80;
	localparam logic [7:0] CMD_CHAN_CONFIG   = 8'hD0;
	localparam logic [7:0] CMD_FAULT_PIN_EN  = 8'hD2;
	localparam logic [7:0] CMD_PAD_STATE     = 8'hE5;
	localparam logic [7:0] CMD_COMMON_STATUS = 8'hEF;
	localparam logic [7:0] CMD_RESTART_INT   = 8'hF5;
	localparam logic [7:0] CMD_SOFT_RESET    = 8'hFD;

	// status bit positions
	localparam int OPERATION_ON_BIT  = 7;
	localparam int VOUT_TON_MAX_BIT  = 0;
	localparam int INPUT_VIN_OV_BIT  = 7;
	localparam int TEMP_OT_BIT       = 7;
	localparam int TEMP_UT_BIT       = 4;
	localparam int CML_BAD_CMD_BIT   = 7;
	localparam int CML_BAD_DATA_BIT  = 6;
	localparam int MFR_FAULT_LOW_BIT = 0;
	localparam int WORD_VOUT_BIT     = 15;
	localparam int WORD_INPUT_BIT    = 13;
	localparam int WORD_MFR_BIT      = 12;
	localparam int BYTE_OFF_BIT      = 6;
	localparam int BYTE_TEMP_BIT     = 2;
	localparam int BYTE_CML_BIT      = 1;
	localparam int CFG_DECAY_BIT     = 0;

	// fault pin enable positions
	localparam int PROP_VIN_OV  = 4;
	localparam int PROP_OT      = 7;
	localparam int PROP_UT      = 8;
	localparam int PROP_TON_MAX = 13;
	localparam int PROP_DECAY   = 15;
	localparam logic [15:0] PROP_WRITABLE = 16'hE997;

	// action byte fields
	localparam logic [1:0] ACT_CONTINUE  = 2'h0;
	localparam logic [1:0] ACT_SHUTDOWN  = 2'h2;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;

	// response slots and alert mask slots
	localparam int NUM_RSP    = 4;
	localparam int RSP_VIN_OV = 0;
	localparam int RSP_OT     = 1;
	localparam int RSP_UT     = 2;
	localparam int RSP_TON    = 3;
	localparam int NUM_MASK   = 6;
	localparam logic [2:0] MSK_VOUT  = 3'h0;
	localparam logic [2:0] MSK_IOUT  = 3'h1;
	localparam logic [2:0] MSK_TEMP  = 3'h2;
	localparam logic [2:0] MSK_CML   = 3'h3;
	localparam logic [2:0] MSK_INPUT = 3'h4;
	localparam logic [2:0] MSK_MFR   = 3'h5;

	// values after reset
	localparam logic [7:0]  ACTION_RST   = 8'h00;
	localparam logic [15:0] RESTART_RST  = 16'h0078;
	localparam logic [7:0]  MASK_RST     = 8'h00;
	localparam logic [7:0]  MASK_MFR_RST = 8'h11;
	localparam logic [15:0] PROP_RST     = 16'h0000;
	localparam logic [7:0]  CHAN_CFG_RST = 8'h01;
	localparam logic [7:0]  OPER_RST     = 8'h80;

	// timing
	localparam int unsigned CLK_HZ        = 25000000;
	localparam int unsigned MS_PER_SECOND = 1000;
	localparam int unsigned MS_CYCLES     = CLK_HZ / MS_PER_SECOND;
endpackage
`default_nettype wire

//--- core/frac_restart_timer.sv
`default_nettype none
module frac_restart_timer #(
	parameter int unsigned MS_CYCLES = frac_pkg::MS_CYCLES
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	// control
	input  wire logic        count_en_i,
	input  wire logic [15:0] interval_i,
	input  wire logic        decay_ok_i,
	// status
	output logic             restart_o,
	output logic             waiting_decay_o
);
	import frac_pkg::*;

	logic [15:0] div_q;
	logic [15:0] ms_q;
	logic [15:0] target_ms;
	logic        tick;
	logic        elapsed;

	// linear word to whole milliseconds, saturating; negative mantissa reads as zero
	function automatic logic [15:0] lin_to_ms(input logic [15:0] lin);
		logic signed [4:0]  ex;
		logic        [31:0] m;
		logic        [31:0] r;
		ex = lin[15:11];
		m  = lin[10] ? 32'h0 : {21'h0, lin[10:0]};
		if (ex < 0) r = m >> (-ex);
		else        r = m << ex;
		return (r > 32'h0000FFFF) ? 16'hFFFF : r[15:0];
	endfunction

	assign target_ms = lin_to_ms(interval_i);
	assign tick      = (div_q == 16'(MS_CYCLES - 1));
	assign elapsed   = (ms_q >= target_ms);

	always_ff @(posedge clk_i) begin
		if (srst_i || !count_en_i || tick) div_q <= 16'h0000;
		else                               div_q <= div_q + 16'h0001;
	end

	// counting held at zero until the fault has gone
	always_ff @(posedge clk_i) begin
		if (srst_i || !count_en_i)       ms_q <= 16'h0000;
		else if (tick && ms_q != 16'hFFFF) ms_q <= ms_q + 16'h0001;
	end

	assign restart_o       = count_en_i && elapsed && decay_ok_i;
	assign waiting_decay_o = count_en_i && elapsed && !decay_ok_i;
endmodule // frac_restart_timer
`default_nettype wire

//--- tb/frac_fault_ctrl_monitor.sv
`default_nettype none
module frac_fault_ctrl_monitor
	import frac_pkg::*;
#(
	parameter int unsigned MS_CYCLES = 10
) (
	// clock and reset
	input wire logic        clk_i,
	input wire logic        srst_i,
	// command port
	input wire logic        cmd_valid_i,
	input wire logic [1:0]  cmd_kind_i,
	input wire logic        rsp_valid_o,
	input wire logic [15:0] rsp_rdata_o,
	// faults and pins
	input wire logic [15:0] fault_cond_i,
	input wire logic        run_pin_i,
	input wire logic        fault_pin_i,
	input wire logic        fault_pin_oe_o,
	input wire logic        alert_pin_oe_o,
	input wire logic        output_enable_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	// six cycles: sync, status, alert; wider hides slow logic
	logic [5:0] cause_q;
	logic [5:0] cmd_q;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cause_q <= 6'h00;
			cmd_q <= 6'h00;
		end else begin
			cause_q <= {cause_q[4:0], |fault_cond_i | cmd_valid_i | !fault_pin_i | !run_pin_i};
			cmd_q <= {cmd_q[4:0], cmd_valid_i | !run_pin_i};
		end
	end

	chk_rsp_one_cycle: assert property (cmd_valid_i |-> ##1 rsp_valid_o)
		else $error("command not answered one cycle later");
	chk_rsp_quiet: assert property (!cmd_valid_i |=> !rsp_valid_o)
		else $error("answer without a command");
	chk_write_no_data: assert property (cmd_valid_i && cmd_kind_i == KIND_WRITE |=> rsp_rdata_o == 16'h0000)
		else $error("write answered with data");
	chk_off_has_cause: assert property ($fell(output_enable_o) |-> |cause_q)
		else $error("output dropped without a cause");
	chk_alert_has_cause: assert property ($rose(alert_pin_oe_o) |-> |cause_q)
		else $error("alert raised without a cause");
	chk_alert_sticky: assert property ($fell(alert_pin_oe_o) |-> |cmd_q)
		else $error("alert released without a clear");
	chk_pin_has_cause: assert property ($rose(fault_pin_oe_o) |-> $past(fault_cond_i) != 16'h0000
		|| !$past(output_enable_o) || $past(cmd_valid_i))
		else $error("fault pin pulled without a condition");
	chk_pin_release: assert property (fault_cond_i == 16'h0000 && output_enable_o |=> !fault_pin_oe_o)
		else $error("fault pin held with no condition");

	cov_alert: cover property ($rose(alert_pin_oe_o));
	cov_shutdown: cover property ($fell(output_enable_o));
	cov_restart: cover property ($rose(output_enable_o));
	cov_fault_pin: cover property ($rose(fault_pin_oe_o));
endmodule // frac_fault_ctrl_monitor

bind frac_fault_ctrl frac_fault_ctrl_monitor #(.MS_CYCLES(MS_CYCLES)) i_frac_fault_ctrl_monitor (
	.clk_i(clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i), .cmd_kind_i(cmd_kind_i),
	.rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .fault_cond_i(fault_cond_i),
	.run_pin_i(run_pin_i), .fault_pin_i(fault_pin_i), .fault_pin_oe_o(fault_pin_oe_o),
	.alert_pin_oe_o(alert_pin_oe_o), .output_enable_o(output_enable_o)
);
`default_nettype wire

//--- tb/frac_fault_ctrl_test.sv
`default_nettype none
module frac_fault_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	import frac_pkg::*;
	localparam int unsigned MSC = 10;
	logic        clk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic        run_pin_i = 1'b1;
	logic        vout_decayed_i = 1'b0;
	logic [15:0] fault_cond_i = 16'h0000;
	wire logic   fault_pin_i;
	wire logic        cmd_valid_i;
	wire logic [1:0]  cmd_kind_i;
	wire logic [7:0]  cmd_code_i;
	wire logic [15:0] cmd_wdata_i;
	logic rsp_valid_o, fault_pin_o, fault_pin_oe_o, alert_pin_o, alert_pin_oe_o, output_enable_o;
	logic [15:0] rsp_rdata_o, rd;
	logic [7:0]  w, old;
	int mismatches = 0;
	int cmp_count = 0;
	int n;
	logic [7:0] mcode [6] = '{CMD_STATUS_VOUT, CMD_STATUS_IOUT, CMD_STATUS_TEMP,
		CMD_STATUS_CML, CMD_STATUS_INPUT, CMD_STATUS_MFR};
	logic [7:0] bad [4] = '{CMD_STATUS_BYTE, CMD_STATUS_WORD, CMD_COMMON_STATUS, CMD_PAD_STATE};
	logic [7:0] acode [4] = '{CMD_VIN_OV_RESP, CMD_OT_RESP, CMD_UT_RESP, CMD_TON_MAX_RESP};

	always #20 clk_i = ~clk_i;
	// pulled-up fault wire, only the design pulls it
	assign fault_pin_i = ~fault_pin_oe_o;

	frac_fault_ctrl #(.MS_CYCLES(MSC)) i_frac_fault_ctrl (.clk_i(clk_i), .srst_i(srst_i),
		.cmd_valid_i(cmd_valid_i), .cmd_kind_i(cmd_kind_i), .cmd_code_i(cmd_code_i),
		.cmd_wdata_i(cmd_wdata_i), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
		.fault_cond_i(fault_cond_i), .run_pin_i(run_pin_i), .vout_decayed_i(vout_decayed_i),
		.fault_pin_i(fault_pin_i), .fault_pin_o(fault_pin_o), .fault_pin_oe_o(fault_pin_oe_o),
		.alert_pin_o(alert_pin_o), .alert_pin_oe_o(alert_pin_oe_o),
		.output_enable_o(output_enable_o));
	frac_host_model i_frac_host_model (.clk_i(clk_i), .rsp_valid_i(rsp_valid_o),
		.rsp_rdata_i(rsp_rdata_o), .cmd_valid_o(cmd_valid_i), .cmd_kind_o(cmd_kind_i),
		.cmd_code_o(cmd_code_i), .cmd_wdata_o(cmd_wdata_i));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic tx(input logic [1:0] k, input logic [7:0] c, input logic [15:0] d);
		logic ok;
		i_frac_host_model.xfer(k, c, d, rd, ok);
		check({15'h0000, ok}, 16'h0001);
	endtask
	task automatic wait_oe(input logic v, input int lim);
		n = 0;
		while (output_enable_o !== v && n < lim) begin
			@(negedge clk_i);
			n++;
		end
	endtask
	task automatic set_cond(input int b, input logic v);
		@(negedge clk_i);
		fault_cond_i[b] = v;
	endtask
	function automatic logic [7:0] exp_action(input logic [7:0] was, input logic [7:0] wr);
		return wr[6] ? was : {wr[7:3], 3'b000};
	endfunction
	function automatic int restart_cycles(input int ms);
		return ms * MSC;
	endfunction
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge clk_i);
		mismatches++;
		$display("unexpected at %0t: watchdog expired", $time);
		report_and_stop();
	end

	initial begin
		n = $urandom(32'h5076C43D);
		repeat (12) @(posedge clk_i);
		@(negedge clk_i);
		srst_i = 1'b0;
		wait_oe(1'b1, 20);
		foreach (mcode[i]) begin
			tx(KIND_PROC, CMD_ALERT_MASK, {8'h00, mcode[i]});
			check(rd, (i == 5) ? 16'h0011 : 16'h0000);
		end
		foreach (bad[i]) begin
			tx(KIND_WRITE, CMD_ALERT_MASK, {8'hFF, bad[i]});
			tx(KIND_PROC, CMD_ALERT_MASK, {8'h00, bad[i]});
			check(rd, 16'h0000);
			tx(KIND_READ, CMD_STATUS_CML, 16'h0000);
			check(rd & 16'h0040, 16'h0040);
			tx(KIND_WRITE, CMD_CLEAR_FAULTS, 16'h0000);
		end
		// all action codes, random low bits
		for (int k = 0; k < 16; k++) begin
			w = {k[3:2], 6'($urandom)};
			tx(KIND_READ, acode[k % 4], 16'h0000);
			old = rd[7:0];
			tx(KIND_WRITE, acode[k % 4], {8'h00, w});
			tx(KIND_READ, acode[k % 4], 16'h0000);
			check(rd, {8'h00, exp_action(old, w)});
			tx(KIND_READ, CMD_STATUS_CML, 16'h0000);
			check({15'h0000, rd[CML_BAD_DATA_BIT]}, {15'h0000, w[6]});
			tx(KIND_WRITE, CMD_CLEAR_FAULTS, 16'h0000);
		end
		// ignored timeout: status and alert only
		tx(KIND_WRITE, CMD_TON_MAX_RESP, 16'h0000);
		tx(KIND_WRITE, CMD_FAULT_PIN_EN, 16'h2000);
		set_cond(PROP_TON_MAX, 1'b1);
		repeat (4) @(negedge clk_i);
		check({13'h0000, alert_pin_oe_o, output_enable_o, fault_pin_oe_o}, 16'h0006);
		check({14'h0000, fault_pin_o, alert_pin_o}, 16'h0000);
		tx(KIND_READ, CMD_STATUS_WORD, 16'h0000);
		check(rd & 16'h8000, 16'h8000);
		tx(KIND_READ, CMD_STATUS_VOUT, 16'h0000);
		check(rd & 16'h0001, 16'h0001);
		tx(KIND_WRITE, CMD_ALERT_MASK, {8'h01, CMD_STATUS_VOUT});
		tx(KIND_PROC, CMD_ALERT_MASK, {8'h00, CMD_STATUS_VOUT});
		check(rd, 16'h0001);
		set_cond(PROP_TON_MAX, 1'b0);
		tx(KIND_WRITE, CMD_CLEAR_FAULTS, 16'h0000);
		set_cond(PROP_TON_MAX, 1'b1);
		repeat (4) @(negedge clk_i);
		tx(KIND_READ, CMD_STATUS_VOUT, 16'h0000);
		check({14'h0000, rd[0], alert_pin_oe_o}, 16'h0002);
		set_cond(PROP_TON_MAX, 1'b0);
		// no-retry shutdown; pin ignores alert mask
		w = {2'b10, 3'($urandom_range(6)), 3'b000};
		tx(KIND_WRITE, CMD_TON_MAX_RESP, {8'h00, w});
		tx(KIND_WRITE, CMD_CLEAR_FAULTS, 16'h0000);
		set_cond(PROP_TON_MAX, 1'b1);
		wait_oe(1'b0, 5);
		check({15'h0000, n <= 2}, 16'h0001);
		check({15'h0000, fault_pin_oe_o}, 16'h0001);
		set_cond(PROP_TON_MAX, 1'b0);
		repeat (2000) @(negedge clk_i);
		check({14'h0000, output_enable_o, fault_pin_oe_o}, 16'h0000);
		tx(KIND_WRITE, CMD_CLEAR_FAULTS, 16'h0000);
		wait_oe(1'b1, 10);
		check({15'h0000, output_enable_o}, 16'h0001);
		// endless retry: decay gate first, then the interval alone
		tx(KIND_WRITE, CMD_RESTART_INT, 16'h0082);
		tx(KIND_WRITE, CMD_OT_RESP, 16'h00B8);
		for (int k = 0; k < 3; k++) begin
			if (k == 1) tx(KIND_WRITE, CMD_CHAN_CONFIG, 16'h0000);
			set_cond(PROP_OT, 1'b1);
			wait_oe(1'b0, 5);
			repeat (400) @(negedge clk_i);
			set_cond(PROP_OT, 1'b0);
			wait_oe(1'b1, 1600);
			if (k == 0) begin
				check({15'h0000, output_enable_o}, 16'h0000);
				vout_decayed_i = 1'b1;
				wait_oe(1'b1, 10);
				check({15'h0000, output_enable_o}, 16'h0001);
				vout_decayed_i = 1'b0;
			end else begin
				check({15'h0000, n >= restart_cycles(130) - 2 && n <= restart_cycles(130) + 10},
					16'h0001);
			end
		end
		report_and_stop();
	end
endmodule // frac_fault_ctrl_test
`default_nettype wire

//--- tb/frac_host_model.sv
`default_nettype none
module frac_host_model (
	// clock and answer
	input  wire logic        clk_i,
	input  wire logic        rsp_valid_i,
	input  wire logic [15:0] rsp_rdata_i,
	// request
	output var logic         cmd_valid_o,
	output var logic [1:0]   cmd_kind_o,
	output var logic [7:0]   cmd_code_o,
	output var logic [15:0]  cmd_wdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cmd_valid_o = 1'b0;
		cmd_kind_o = 2'h0;
		cmd_code_o = 8'h00;
		cmd_wdata_o = 16'h0000;
	end
	// word low byte first; mask code in first byte, mask in second
	task automatic xfer(input logic [1:0] kind, input logic [7:0] code, input logic [15:0] wd,
			output logic [15:0] rd, output logic ok);
		@(negedge clk_i);
		cmd_valid_o = 1'b1;
		cmd_kind_o = kind;
		cmd_code_o = code;
		cmd_wdata_o = wd;
		@(negedge clk_i);
		// answer stands only until the next edge; take it first
		ok = rsp_valid_i;
		rd = rsp_rdata_i;
		cmd_valid_o = 1'b0;
		cmd_code_o = ~code;
		cmd_wdata_o = ~wd;
	endtask
endmodule // frac_host_model
`default_nettype wire
